/* design/mwd_delay.sv */
// Reset delay counter that stretches a watchdog reset into a core reset.
`timescale 1ns/10ps
module mwd_delay (
    input wire logic clk,
    input wire logic srst,
    mwd_dly_if.cnt dly
);
    typedef struct packed {
        logic [11:0] cnt;
        logic hold;
        logic [12:0] hold_len;
    } mwd_dly_s;

    mwd_dly_s s;
    mwd_dly_s next_s;

    always_comb begin
        next_s = s;
        // [R12] Count the delay.
        if (dly.start) begin
            next_s.cnt = 12'(mwd_pkg::RESET_DELAY_CYC - 1);
            next_s.hold = 1'b1;
        end else if (s.cnt != 12'h000) begin
            next_s.cnt = s.cnt - 12'h001;
        end else begin
            next_s.hold = 1'b0;
        end
        // The held length feeds only the span check below.
        if (!s.hold) begin
            next_s.hold_len = 13'h0000;
        end else begin
            next_s.hold_len = s.hold_len + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dly.hold = s.hold;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_delay_span: assert property ( // [R12]
        $fell(s.hold) |-> s.hold_len == 13'(mwd_pkg::RESET_DELAY_CYC))
        else $error("Reset delay did not last its set period.");

    chk_delay_begin: assert property ( // [R12]
        dly.start |=> s.hold [*8])
        else $error("Reset delay did not begin after its start.");
endmodule

/* design/mwd_dly_if.sv */
// Handshake between the watchdog core and its reset delay counter.
`timescale 1ns/10ps
interface mwd_dly_if;
    logic start;
    logic hold;
    modport ctl (output start, input hold);
    modport cnt (input start, output hold);
endinterface

/* design/mwd_pkg.sv */
// Constants shared by the watchdog timer and its reset delay counter.
// Operation
// [R1] A time-out that resets emits a one-clock reset pulse, and its falling edge starts the reset delay counter.
// [R2] With the fuse unprogrammed, no enable stops the unit, interrupt enable alone interrupts and reset enable alone resets.
// [R3] With the fuse unprogrammed and both enables set, a time-out interrupts first and then leaves the unit in reset mode.
// [R4] With the always-on fuse programmed (0) every time-out resets, whatever the enable bits hold.
// [R5] Software sets change enable before it clears reset enable or alters the prescaler, otherwise such writes do nothing.
// [R6] Hardware clears change enable four clock cycles after software writes it to one.
// [R7] While the watchdog reset flag is set, reset enable reads as set and cannot be cleared.
// [R8] The 4-bit prescale select takes its high bit from control bit 5 and its low bits from bits 2:0.
// [R9] Prescale codes 0 to 9 select time-outs doubling from 2K up to 1024K watchdog oscillator cycles.
// [R10] Change enable sits at control bit 4 and reset enable at control bit 3.
// [R11] Reserved prescale codes 10 to 15 give the longest defined time-out.
// [R12] The reset delay counter holds the core in reset for its set period after the pulse, then releases it.
package mwd_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_PERIOD_PS = 7812500;
    localparam int OSC_DIV_CYC = OSC_PERIOD_PS / CLK_PERIOD_PS;
    localparam int RESET_DELAY_NS = 100000;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_WINDOW_CYC = 4;
    localparam logic [4:0] BASE_LOG2 = 5'h0b;
    localparam logic [3:0] PRESCALE_MAX = 4'h9;
    localparam logic [20:0] LONGEST_LIMIT = 21'h100000;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CAUSE = 8'h04;
    localparam logic [7:0] ADDR_KICK = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam int BIT_SRE = 3;
    localparam int BIT_CE = 4;
    localparam int BIT_PRE_HI = 5;
    localparam int BIT_TIE = 6;
    localparam int BIT_FLAG = 3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_WDRESET = 1;
    localparam logic [3:0] PRE_RST = 4'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
endpackage

/* design/mwd_top.sv */
// Watchdog timer with an AHB-Lite register slave and a level interrupt.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module mwd_top #(
    parameter int OSC_DIV = mwd_pkg::OSC_DIV_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic ALWAYS_ON_FUSE,
    output logic IRQ,
    output logic WDT_RESET_PULSE,
    output logic CORE_RESET
);
    typedef struct packed {
        logic fuse_s1;
        logic fuse_s2;
        logic [8:0] tick_cnt;
        logic tick;
        logic [20:0] tcnt;
        logic tie;
        logic sre;
        logic [3:0] pre;
        logic ce;
        logic [1:0] ce_cnt;
        logic rst_flag;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic pulse;
        logic start;
        logic core;
        logic [31:0] hrdata;
        logic rdy;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
    } mwd_top_s;

    mwd_top_s s;
    mwd_top_s next_s;
    logic fuse_prog;
    logic sre_eff;
    logic enabled;
    logic timeout;
    logic kick;
    logic ctrl_wr;
    logic accept;
    logic [3:0] code;
    logic [20:0] limit;
    logic [7:0] wbyte;

    mwd_dly_if dly ();

    mwd_delay u_delay (
        .clk(CLK),
        .srst(SRST),
        .dly(dly)
    );

    assign dly.start = s.start;

    always_comb begin
        next_s = s;
        wbyte = HWDATA[7:0];
        // The fuse is a pin level, so it is synchronised before use.
        next_s.fuse_s1 = ALWAYS_ON_FUSE;
        next_s.fuse_s2 = s.fuse_s1;
        fuse_prog = !s.fuse_s2;
        // The watchdog oscillator is modelled as a tick enable from a divider.
        // A smaller divider shortens every time-out by the same factor, nothing else.
        if (s.tick_cnt == 9'(OSC_DIV - 1)) begin
            next_s.tick_cnt = 9'h000;
            next_s.tick = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 9'h001;
            next_s.tick = 1'b0;
        end
        // [R7] Flag forces reset enable.
        sre_eff = s.sre | s.rst_flag;
        // [R11] Reserved codes clamp.
        code = (s.pre > mwd_pkg::PRESCALE_MAX) ? mwd_pkg::PRESCALE_MAX : s.pre;
        // [R9] Doubling time-out length.
        // The shift is at most twenty, so the limit always fits its 21 bits.
        limit = 21'h000001 << (mwd_pkg::BASE_LOG2 + {1'b0, code});
        enabled = fuse_prog | sre_eff | s.tie;
        timeout = enabled && s.tick && (s.tcnt == limit - 21'h000001);

        // [R6] Change window countdown.
        if (s.ce) begin
            if (s.ce_cnt == 2'h0) begin
                next_s.ce = 1'b0;
            end else begin
                next_s.ce_cnt = s.ce_cnt - 2'h1;
            end
        end

        // Data phase of a write accepted in the previous cycle.
        kick = 1'b0;
        ctrl_wr = 1'b0;
        if (s.dp_valid && s.dp_write) begin
            unique case (s.dp_addr)
                mwd_pkg::ADDR_CTRL: begin
                    ctrl_wr = 1'b1;
                    next_s.tie = wbyte[mwd_pkg::BIT_TIE];
                    // [R5] Protected clear of reset enable.
                    if (wbyte[mwd_pkg::BIT_SRE]) begin
                        next_s.sre = 1'b1;
                    end else if (s.ce && !s.rst_flag) begin
                        next_s.sre = 1'b0;
                    end
                    // [R8] Prescale field assembly.
                    if (s.ce) begin
                        next_s.pre = {wbyte[mwd_pkg::BIT_PRE_HI], wbyte[2:0]};
                    end
                    // [R10] Change enable opens window.
                    if (wbyte[mwd_pkg::BIT_CE]) begin
                        next_s.ce = 1'b1;
                        next_s.ce_cnt = 2'(mwd_pkg::CE_WINDOW_CYC - 1);
                    end
                end
                mwd_pkg::ADDR_CAUSE: begin
                    if (!wbyte[mwd_pkg::BIT_FLAG]) begin
                        next_s.rst_flag = 1'b0;
                    end
                end
                mwd_pkg::ADDR_KICK: kick = 1'b1;
                mwd_pkg::ADDR_MASK: next_s.mask = wbyte[1:0];
                default: begin
                end
            endcase
        end

        // Address phase: read data is captured here, so the slave never waits.
        accept = HSEL && HTRANS[1] && HREADY;
        next_s.dp_valid = accept;
        next_s.dp_write = HWRITE;
        next_s.dp_addr = HADDR[7:0];
        next_s.hrdata = 32'h00000000;
        if (accept && !HWRITE) begin
            unique case (HADDR[7:0])
                mwd_pkg::ADDR_CTRL: begin
                    next_s.hrdata[7:0] = {1'b0, s.tie, s.pre[3], s.ce, sre_eff, s.pre[2:0]};
                end
                mwd_pkg::ADDR_CAUSE: next_s.hrdata[mwd_pkg::BIT_FLAG] = s.rst_flag;
                mwd_pkg::ADDR_STATUS: begin
                    next_s.hrdata[1:0] = s.status;
                    next_s.status = 2'h0;
                end
                mwd_pkg::ADDR_MASK: next_s.hrdata[1:0] = s.mask;
                mwd_pkg::ADDR_COUNT: next_s.hrdata[20:0] = s.tcnt;
                default: begin
                end
            endcase
        end
        next_s.rdy = 1'b1;

        if (!enabled || kick || timeout) begin
            next_s.tcnt = 21'h000000;
        end else if (s.tick) begin
            next_s.tcnt = s.tcnt + 21'h000001;
        end

        // Hardware events come last so that a hardware event beats a software write.
        // [R1] One-clock pulse, then delay start.
        next_s.pulse = 1'b0;
        next_s.start = s.pulse;
        if (timeout) begin
            // [R4] Fuse forces reset mode.
            if (fuse_prog) begin
                next_s.pulse = 1'b1;
            // [R3] Interrupt, then reset mode.
            end else if (s.tie && sre_eff) begin
                next_s.status[mwd_pkg::ST_TIMEOUT] = 1'b1;
                next_s.tie = 1'b0;
            // [R2] Mode from enables.
            end else if (s.tie) begin
                next_s.status[mwd_pkg::ST_TIMEOUT] = 1'b1;
            end else begin
                next_s.pulse = 1'b1;
            end
        end
        if (next_s.pulse) begin
            next_s.rst_flag = 1'b1;
            next_s.status[mwd_pkg::ST_WDRESET] = 1'b1;
        end
        // [R12] Core held through the delay.
        next_s.core = next_s.pulse | next_s.start | s.start | dly.hold;
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s <= '0;
            // The fuse synchroniser starts unprogrammed, so no false reset follows.
            s.fuse_s1 <= 1'b1;
            s.fuse_s2 <= 1'b1;
            s.pre <= mwd_pkg::PRE_RST;
            s.mask <= mwd_pkg::MASK_RST;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign HRDATA = s.hrdata;
    assign HREADYOUT = s.rdy;
    assign HRESP = 1'b0;
    assign IRQ = s.irq;
    assign WDT_RESET_PULSE = s.pulse;
    assign CORE_RESET = s.core;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    // A rewrite of the control bits reloads the window, so the sequence excludes it.
    sequence ce_opened;
        $rose(s.ce) ##0 (!ctrl_wr) [*4];
    endsequence

    sequence pulse_then_delay;
        s.pulse ##1 s.start ##1 dly.hold;
    endsequence

    chk_pulse_single: assert property ( // [R1]
        s.pulse |=> !s.pulse)
        else $error("Watchdog reset pulse longer than one clock.");

    chk_delay_start: assert property ( // [R1]
        s.pulse |-> pulse_then_delay)
        else $error("Delay counter did not start after the pulse.");

    chk_int_only: assert property ( // [R2]
        timeout && s.fuse_s2 && s.tie && !sre_eff && !ctrl_wr
            |=> s.status[0] && !s.pulse && s.tie)
        else $error("Interrupt mode time-out misbehaved.");

    chk_int_then_reset: assert property ( // [R3]
        timeout && s.fuse_s2 && s.tie && sre_eff |=> s.status[0] && !s.tie && !s.pulse)
        else $error("Combined mode did not interrupt then switch to reset.");

    chk_fuse_forces: assert property ( // [R4]
        timeout && !s.fuse_s2 |=> s.pulse && s.rst_flag)
        else $error("Programmed fuse did not force a reset.");

    chk_protect_pre: assert property ( // [R5]
        !s.ce |=> s.pre == $past(s.pre))
        else $error("Prescale changed without change enable.");

    chk_ce_window: assert property ( // [R6]
        ce_opened |-> s.ce ##1 !s.ce)
        else $error("Change enable not cleared after four cycles.");

    chk_locked_sre: assert property ( // [R7]
        s.rst_flag && s.sre |=> s.sre)
        else $error("Reset enable cleared while the reset flag was set.");

    chk_pre_field: assert property ( // [R8]
        ctrl_wr && s.ce |=> s.pre == {$past(HWDATA[5]), $past(HWDATA[2:0])})
        else $error("Prescale field not taken from bits 5 and 2:0.");

    chk_reserved_code: assert property ( // [R11]
        s.pre > 4'h9 |-> limit == mwd_pkg::LONGEST_LIMIT)
        else $error("Reserved prescale code not clamped to the longest.");

    chk_core_hold: assert property ( // [R12]
        s.start |=> s.core [*8])
        else $error("Core reset not held during the delay.");

    // The lock is checked on the read path, where software would see it.
    chk_flag_reads: assert property ( // [R7]
        accept && !HWRITE && HADDR[7:0] == mwd_pkg::ADDR_CTRL && s.rst_flag
            |=> s.hrdata[mwd_pkg::BIT_SRE])
        else $error("Reset enable did not read as set while the flag was set.");

    chk_limit_code: assert property ( // [R9]
        s.pre <= mwd_pkg::PRESCALE_MAX |-> limit == (21'h000800 << s.pre))
        else $error("Time-out length does not double per prescale step.");

    chk_flag_event: assert property ( // [R1]
        s.pulse |-> s.rst_flag && s.status[mwd_pkg::ST_WDRESET])
        else $error("Watchdog reset did not set its flag and event bit.");

    chk_irq_level: assert property ( // [R2]
        s.irq == |(s.status & s.mask))
        else $error("Interrupt level does not follow the masked status.");

    chk_ce_load: assert property ( // [R10]
        ctrl_wr && HWDATA[mwd_pkg::BIT_CE] |=> s.ce && s.ce_cnt == 2'h3)
        else $error("Change enable bit did not open its window.");

    chk_stopped_unit: assert property ( // [R2]
        s.fuse_s2 && !s.sre && !s.rst_flag && !s.tie |=> s.tcnt == 21'h000000)
        else $error("Stopped watchdog kept counting.");
endmodule

/* verification/mwd_top_test.sv */
// Self-checking bench for the watchdog timer, its register slave and its reset path.
`timescale 1ns/10ps
module mwd_top_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic fuse = 1'b1;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    logic pulse;
    logic core_reset;
    logic hresp;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    // The oscillator divider is cut to one so the shortest time-out is 2048 clocks.
    mwd_top #(.OSC_DIV(1)) dut (
        .CLK(clk),
        .SRST(srst),
        .HSEL(hsel),
        .HADDR(haddr),
        .HTRANS(htrans),
        .HWRITE(hwrite),
        .HSIZE(3'h2),
        .HWDATA(hwdata),
        .HREADY(hreadyout),
        .HRDATA(hrdata),
        .HREADYOUT(hreadyout),
        .HRESP(hresp),
        .ALWAYS_ON_FUSE(fuse),
        .IRQ(irq),
        .WDT_RESET_PULSE(pulse),
        .CORE_RESET(core_reset)
    );

    always #12.5 clk = ~clk;

    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the roughly 23000 cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            $display("[ERR] %0t run did not finish", $time);
            close_out();
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk32(r, exp);
    endtask

    // Counts clocks until the interrupt (sel 0) or the reset pulse (sel 1) shows.
    task automatic wait_for(input int sel, input int lo, input int hi);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((sel == 0) ? irq : pulse) !== 1'b1 && n < hi + 50);
        chk_rng(n, lo, hi);
    endtask

    // Entered at the edge that sees the pulse; measures pulse width and core reset length.
    task automatic reset_len;
        chk32({31'h0, core_reset}, 32'h1);
        @(posedge clk);
        chk32({31'h0, pulse}, 32'h0);
        n = 1;
        while (core_reset === 1'b1 && n < 5000) begin
            n++;
            @(posedge clk);
        end
        chk_rng(n, mwd_pkg::RESET_DELAY_CYC + 3, mwd_pkg::RESET_DELAY_CYC + 3);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(mwd_pkg::ADDR_CTRL, 32'h0);
        rd(mwd_pkg::ADDR_CAUSE, 32'h0);
        rd(mwd_pkg::ADDR_MASK, 32'h0);
        wr(mwd_pkg::ADDR_CTRL, 32'h27);
        chk32({30'h0, hresp, hreadyout}, 32'h1);
        rd(mwd_pkg::ADDR_CTRL, 32'h0);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        rd(mwd_pkg::ADDR_CTRL, 32'h10);
        // The next read samples the bits five edges after the write, past the window.
        rd(mwd_pkg::ADDR_CTRL, 32'h0);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h21);
        repeat (8) @(posedge clk);
        rd(mwd_pkg::ADDR_CTRL, 32'h21);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h27);
        rd(mwd_pkg::ADDR_CTRL, 32'h27);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h00);
        // Interrupt-only mode at the shortest time-out.
        wr(mwd_pkg::ADDR_MASK, 32'h1);
        wr(mwd_pkg::ADDR_CTRL, 32'h40);
        wr(mwd_pkg::ADDR_KICK, 32'h0);
        rd(mwd_pkg::ADDR_COUNT, 32'h1);
        wait_for(0, 2040, 2060);
        chk32({31'h0, pulse}, 32'h0);
        rd(mwd_pkg::ADDR_STATUS, 32'h1);
        rd(mwd_pkg::ADDR_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        chk32({31'h0, irq}, 32'h0);
        rd(mwd_pkg::ADDR_CTRL, 32'h40);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h01);
        // Both enables at code one: interrupt first, then a reset.
        wr(mwd_pkg::ADDR_CTRL, 32'h49);
        wr(mwd_pkg::ADDR_KICK, 32'h0);
        wait_for(0, 4090, 4110);
        rd(mwd_pkg::ADDR_CTRL, 32'h09);
        rd(mwd_pkg::ADDR_STATUS, 32'h1);
        wait_for(1, 3980, 4110);
        reset_len();
        rd(mwd_pkg::ADDR_CAUSE, 32'h08);
        rd(mwd_pkg::ADDR_STATUS, 32'h2);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h01);
        repeat (4) @(posedge clk);
        rd(mwd_pkg::ADDR_CTRL, 32'h09);
        wr(mwd_pkg::ADDR_CAUSE, 32'h0);
        rd(mwd_pkg::ADDR_CTRL, 32'h09);
        wr(mwd_pkg::ADDR_CTRL, 32'h10);
        wr(mwd_pkg::ADDR_CTRL, 32'h01);
        repeat (4) @(posedge clk);
        rd(mwd_pkg::ADDR_CTRL, 32'h01);
        // A programmed fuse forces reset mode although both enables are clear.
        fuse <= 1'b0;
        wr(mwd_pkg::ADDR_KICK, 32'h0);
        wait_for(1, 4080, 4110);
        reset_len();
        rd(mwd_pkg::ADDR_CAUSE, 32'h08);
        rd(mwd_pkg::ADDR_CTRL, 32'h09);
        fuse <= 1'b1;
        wr(mwd_pkg::ADDR_CAUSE, 32'h0);
        rd(mwd_pkg::ADDR_CTRL, 32'h01);
        close_out();
    end
endmodule
